/* File: hw/tsa_alarm.sv */
// thermal limit comparators, alarm pin control and configuration registers
//
// Functional notes
// - window status bits with selectable hysteresis
// - shutdown freezes sensing, alarms and data
// - shutdown cannot be set while locked
// - bit 7 locks critical limit until reset
// - bit 6 locks high/low limits until reset
// - bit 5 releases alarm, reads zero
// - release ignored in comparator mode
// - bit 4 shows alarm being asserted
// - bit 3 enables alarm, frozen when locked
// - bit 2 selects critical-only alarm
// - critical-only bit frozen by window lock
// - bit 1 selects asserted pin level
// - bit 0 comparator or latched interrupt
// - temperatures are two's complement, quarter degree
// - compare bits 12..2, show the bits kept by the resolution mask
// - high limit at 02, bits 12..2, resets zero
// - alarm on crossing high limit either way
// - critical alarm holds until at or below limit minus hysteresis
// - hysteresis frozen while either lock set
// - alarm on crossing low limit either way
`timescale 1ns/1ps
`include "tsa_regs.svh"
module tsa_alarm (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    // converter
    input wire logic [12:0] temp_sample,
    input wire logic sample_valid,
    input wire logic [1:0] resolution_code,
    output logic converter_enable,
    // register access on the link clock
    input wire logic lnk_req,
    input wire logic lnk_wr,
    input wire logic [7:0] lnk_addr,
    input wire logic [15:0] lnk_wdata,
    output logic lnk_busy,
    output logic lnk_done,
    output logic [15:0] lnk_rdata,
    // open-drain alarm pin
    output logic alarm_pin_o,
    output logic alarm_pin_oe
);
    logic sys_req;
    logic sys_wr;
    logic [7:0] sys_addr;
    logic [15:0] sys_wdata;
    logic [15:0] sys_rdata;

    tsa_link_xfer u_xfer (
        .clk_sys(clk_sys),
        .rst(rst),
        .clk_link(clk_link),
        .lnk_req(lnk_req),
        .lnk_wr(lnk_wr),
        .lnk_addr(lnk_addr),
        .lnk_wdata(lnk_wdata),
        .lnk_busy(lnk_busy),
        .lnk_done(lnk_done),
        .lnk_rdata(lnk_rdata),
        .sys_req(sys_req),
        .sys_wr(sys_wr),
        .sys_addr(sys_addr),
        .sys_wdata(sys_wdata),
        .sys_rdata(sys_rdata)
    );

    logic power_down_ctl;
    logic critical_limit_lock;
    logic window_limit_lock;
    logic alarm_enable;
    logic critical_only_select;
    logic alarm_polarity;
    logic alarm_mode;
    tsa_pkg::tsa_hyst_t hyst_sel;
    logic [10:0] upper_bound;
    logic [10:0] lower_bound;
    logic [10:0] critical_limit;
    logic [12:0] temp_data;
    logic st_high;
    logic st_low;
    logic st_crit;
    logic alarm_latch;
    logic alarm_asserted_flag;

    logic wr_cfg;
    logic wr_high;
    logic wr_low;
    logic wr_crit;
    logic any_lock;
    logic upd;
    logic release_wr;
    logic next_pol;
    localparam logic [15:0] cfg_reset_val = `TSA_CFG_RESET;

    assign wr_cfg = sys_req && sys_wr && (sys_addr == `TSA_ADDR_CFG);
    assign wr_high = sys_req && sys_wr && (sys_addr == `TSA_ADDR_HIGH);
    assign wr_low = sys_req && sys_wr && (sys_addr == `TSA_ADDR_LOW);
    assign wr_crit = sys_req && sys_wr && (sys_addr == `TSA_ADDR_CRIT);
    assign any_lock = critical_limit_lock || window_limit_lock;
    assign upd = sample_valid && !power_down_ctl;
    assign release_wr = wr_cfg && sys_wdata[`TSA_CFG_RELEASE] && alarm_mode;
    assign converter_enable = !power_down_ctl;
    assign next_pol = wr_cfg ? sys_wdata[`TSA_CFG_POL] : alarm_polarity;

    // locks only ever set here; rst stands for the internal power-on reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            critical_limit_lock <= cfg_reset_val[`TSA_CFG_CRIT_LOCK];
            window_limit_lock <= cfg_reset_val[`TSA_CFG_WIN_LOCK];
        end else if (wr_cfg) begin
            if (sys_wdata[`TSA_CFG_CRIT_LOCK]) critical_limit_lock <= 1'b1;
            if (sys_wdata[`TSA_CFG_WIN_LOCK]) window_limit_lock <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            power_down_ctl <= cfg_reset_val[`TSA_CFG_POWER_DOWN_CTL];
            hyst_sel <= tsa_pkg::TSA_HYST_OFF;
            alarm_enable <= cfg_reset_val[`TSA_CFG_ENABLE];
            critical_only_select <= cfg_reset_val[`TSA_CFG_CONLY];
            alarm_polarity <= cfg_reset_val[`TSA_CFG_POL];
            alarm_mode <= cfg_reset_val[`TSA_CFG_MODE];
        end else if (wr_cfg) begin
            if (!sys_wdata[`TSA_CFG_POWER_DOWN_CTL]) begin
                power_down_ctl <= 1'b0;
            end else if (!any_lock) begin
                power_down_ctl <= 1'b1;
            end
            if (!any_lock) begin
                hyst_sel <= tsa_pkg::tsa_hyst_t'(sys_wdata[`TSA_CFG_HYST_HI:`TSA_CFG_HYST_LO]);
                alarm_enable <= sys_wdata[`TSA_CFG_ENABLE];
            end
            if (!window_limit_lock) critical_only_select <= sys_wdata[`TSA_CFG_CONLY];
            alarm_polarity <= sys_wdata[`TSA_CFG_POL];
            alarm_mode <= sys_wdata[`TSA_CFG_MODE];
        end
    end

    // only bits 12..2 are stored, so stray low bits cannot upset the comparators
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upper_bound <= `TSA_LIMIT_RESET;
            lower_bound <= `TSA_LIMIT_RESET;
            critical_limit <= `TSA_LIMIT_RESET;
        end else begin
            if (wr_high && !window_limit_lock) upper_bound <= sys_wdata[12:2];
            if (wr_low && !window_limit_lock) lower_bound <= sys_wdata[12:2];
            if (wr_crit && !critical_limit_lock) critical_limit <= sys_wdata[12:2];
        end
    end

    tsa_pkg::tsa_cmp_t t_cmp;
    tsa_pkg::tsa_cmp_t hyst_q;
    tsa_pkg::tsa_cmp_t hi_cmp;
    tsa_pkg::tsa_cmp_t lo_cmp;
    tsa_pkg::tsa_cmp_t cr_cmp;
    logic next_st_high;
    logic next_st_low;
    logic next_st_crit;

    // sign-extended to 12 bits so limit minus hysteresis cannot wrap
    assign t_cmp = tsa_pkg::tsa_cmp_t'({temp_sample[12], temp_sample[12:2]});
    assign hi_cmp = tsa_pkg::tsa_cmp_t'({upper_bound[10], upper_bound});
    assign lo_cmp = tsa_pkg::tsa_cmp_t'({lower_bound[10], lower_bound});
    assign cr_cmp = tsa_pkg::tsa_cmp_t'({critical_limit[10], critical_limit});

    always_comb begin
        unique case (hyst_sel)
            tsa_pkg::TSA_HYST_OFF: hyst_q = 12'sh000;
            tsa_pkg::TSA_HYST_1P5: hyst_q = `TSA_HYST_Q_1P5;
            tsa_pkg::TSA_HYST_3: hyst_q = `TSA_HYST_Q_3;
            tsa_pkg::TSA_HYST_6: hyst_q = `TSA_HYST_Q_6;
        endcase
    end

    always_comb begin
        next_st_high = st_high;
        next_st_low = st_low;
        next_st_crit = st_crit;
        if (t_cmp > hi_cmp) next_st_high = 1'b1;
        else if (t_cmp <= hi_cmp - hyst_q) next_st_high = 1'b0;
        if (t_cmp < lo_cmp - hyst_q) next_st_low = 1'b1;
        else if (t_cmp >= lo_cmp) next_st_low = 1'b0;
        if (t_cmp > cr_cmp) next_st_crit = 1'b1;
        else if (t_cmp <= cr_cmp - hyst_q) next_st_crit = 1'b0;
    end

    logic [12:0] res_mask;

    always_comb begin
        unique case (resolution_code)
            2'h0: res_mask = `TSA_RES_MASK_9;
            2'h1: res_mask = `TSA_RES_MASK_10;
            2'h2: res_mask = `TSA_RES_MASK_11;
            2'h3: res_mask = `TSA_RES_MASK_12;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            temp_data <= `TSA_TEMP_RESET;
            st_high <= 1'b0;
            st_low <= 1'b0;
            st_crit <= 1'b0;
        end else if (upd) begin
            temp_data <= temp_sample & res_mask;
            st_high <= next_st_high;
            st_low <= next_st_low;
            st_crit <= next_st_crit;
        end
    end

    logic cond_now;
    logic cond_next;
    logic alarm_event;
    logic next_alarm;

    assign cond_now = critical_only_select ? st_crit : (st_high || st_low || st_crit);
    assign cond_next = critical_only_select ? next_st_crit
        : (next_st_high || next_st_low || next_st_crit);
    // any change of a watched status is an event, so both crossings alarm
    assign alarm_event = upd && ((critical_only_select ? (next_st_crit != st_crit)
        : ({next_st_high, next_st_low, next_st_crit} != {st_high, st_low, st_crit})));

    // new event beats a release landing on the same edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarm_latch <= 1'b0;
        end else if (alarm_event) begin
            alarm_latch <= 1'b1;
        end else if (release_wr) begin
            alarm_latch <= 1'b0;
        end
    end

    // critical condition keeps the pin asserted even in latched mode
    assign next_alarm = alarm_enable && (alarm_mode ? (alarm_latch || (st_crit && cond_now))
        : cond_now);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarm_asserted_flag <= 1'b0;
            alarm_pin_oe <= 1'b0;
        end else begin
            alarm_asserted_flag <= next_alarm;
            alarm_pin_oe <= next_alarm ^ next_pol;
        end
    end

    // open drain: the high level of an active-high alarm comes from the pull-up
    assign alarm_pin_o = 1'b0;

    always_comb begin
        sys_rdata = 16'h0000;
        unique case (sys_addr)
            `TSA_ADDR_CFG: sys_rdata = {5'h00, hyst_sel, power_down_ctl, critical_limit_lock,
                window_limit_lock, 1'b0, alarm_asserted_flag, alarm_enable,
                critical_only_select, alarm_polarity, alarm_mode};
            `TSA_ADDR_HIGH: sys_rdata = {3'h0, upper_bound, 2'h0};
            `TSA_ADDR_LOW: sys_rdata = {3'h0, lower_bound, 2'h0};
            `TSA_ADDR_CRIT: sys_rdata = {3'h0, critical_limit, 2'h0};
            `TSA_ADDR_TEMP: sys_rdata = {st_crit, st_high, st_low, temp_data};
            default: sys_rdata = 16'h0000;
        endcase
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_crit_lock_sticky;
        critical_limit_lock |=> critical_limit_lock;
    endproperty
    a_crit_lock_sticky: assert property (p_crit_lock_sticky) else $error("critical lock cleared");

    property p_win_lock_blocks;
        window_limit_lock && wr_high |=> $stable(upper_bound) [*2];
    endproperty
    a_win_lock_blocks: assert property (p_win_lock_blocks) else $error("locked high limit changed");

    property p_power_down_ctl_refused;
        any_lock && !power_down_ctl |=> !power_down_ctl;
    endproperty
    a_power_down_ctl_refused: assert property (p_power_down_ctl_refused) else $error("shutdown set while locked");

    property p_power_down_ctl_freeze;
        power_down_ctl |=> $stable(temp_data) && $stable({st_high, st_low, st_crit});
    endproperty
    a_power_down_ctl_freeze: assert property (p_power_down_ctl_freeze) else $error("data updated in shutdown");

    property p_pin_level;
        (alarm_pin_oe == (alarm_asserted_flag ^ alarm_polarity)) && !alarm_pin_o;
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("alarm pin level wrong");

    property p_masked;
        !alarm_enable |=> !alarm_asserted_flag;
    endproperty
    a_masked: assert property (p_masked) else $error("alarm asserted while masked");

    property p_hyst_locked;
        any_lock && wr_cfg |=> $stable(hyst_sel) && $stable(alarm_enable);
    endproperty
    a_hyst_locked: assert property (p_hyst_locked) else $error("locked field changed");

    property p_conly_locked;
        window_limit_lock && wr_cfg |=> $stable(critical_only_select);
    endproperty
    a_conly_locked: assert property (p_conly_locked) else $error("critical-only changed");

    property p_comparator;
        !alarm_mode |=> alarm_asserted_flag == $past(alarm_enable && cond_now);
    endproperty
    a_comparator: assert property (p_comparator) else $error("comparator output wrong");

    property p_high_set;
        upd && (t_cmp > hi_cmp) |=> st_high ##1 (alarm_mode || !alarm_enable
            || critical_only_select || alarm_asserted_flag);
    endproperty
    a_high_set: assert property (p_high_set) else $error("high status missed");

    property p_release_comp;
        !alarm_mode && alarm_asserted_flag && wr_cfg && sys_wdata[`TSA_CFG_RELEASE]
            && alarm_enable && cond_now && !upd |=> alarm_asserted_flag;
    endproperty
    a_release_comp: assert property (p_release_comp) else $error("release hit comparator");

    c_refused_power_down_ctl: cover property (any_lock && wr_cfg && sys_wdata[`TSA_CFG_POWER_DOWN_CTL]);
    c_release: cover property (alarm_latch && release_wr ##1 !alarm_latch);
    c_crit_alarm: cover property (st_crit && alarm_asserted_flag);
    c_low_alarm: cover property (st_low && alarm_asserted_flag && !alarm_mode);
endmodule : tsa_alarm

/* File: hw/tsa_link_xfer.sv */
// toggle handshake carrying one register access from the link clock into clk_sys
`timescale 1ns/1ps
module tsa_link_xfer (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    // link side
    input wire logic lnk_req,
    input wire logic lnk_wr,
    input wire logic [7:0] lnk_addr,
    input wire logic [15:0] lnk_wdata,
    output logic lnk_busy,
    output logic lnk_done,
    output logic [15:0] lnk_rdata,
    // system side
    output logic sys_req,
    output logic sys_wr,
    output logic [7:0] sys_addr,
    output logic [15:0] sys_wdata,
    input wire logic [15:0] sys_rdata
);
    logic rst_meta;
    logic rst_link;
    logic req_tgl;
    logic ack_meta;
    logic ack_sync;
    logic ack_prev;
    logic req_meta;
    logic req_sync;
    logic req_prev;
    logic ack_tgl;
    logic [15:0] rdata_hold;

    always_ff @(posedge clk_link) begin
        rst_meta <= rst;
        rst_link <= rst_meta;
    end

    always_ff @(posedge clk_link) begin
        ack_meta <= ack_tgl;
        ack_sync <= ack_meta;
        ack_prev <= ack_sync;
    end

    // request fields stay frozen while busy, so clk_sys may sample them after the toggle
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            req_tgl <= 1'b0;
            lnk_busy <= 1'b0;
            lnk_done <= 1'b0;
            lnk_rdata <= 16'h0000;
            sys_wr <= 1'b0;
            sys_addr <= 8'h00;
            sys_wdata <= 16'h0000;
        end else begin
            lnk_done <= 1'b0;
            if (lnk_req && !lnk_busy) begin
                req_tgl <= ~req_tgl;
                lnk_busy <= 1'b1;
                sys_wr <= lnk_wr;
                sys_addr <= lnk_addr;
                sys_wdata <= lnk_wdata;
            end else if (lnk_busy && (ack_sync ^ ack_prev)) begin
                lnk_busy <= 1'b0;
                lnk_done <= 1'b1;
                lnk_rdata <= rdata_hold;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
        end else begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
            req_prev <= req_sync;
        end
    end

    assign sys_req = req_sync ^ req_prev;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_tgl <= 1'b0;
            rdata_hold <= 16'h0000;
        end else if (sys_req) begin
            ack_tgl <= ~ack_tgl;
            rdata_hold <= sys_rdata;
        end
    end
endmodule : tsa_link_xfer

/* File: hw/tsa_pkg.sv */
// shared types of the thermal alarm block
package tsa_pkg;
    typedef logic signed [11:0] tsa_cmp_t;
    typedef enum logic [1:0] {TSA_HYST_OFF, TSA_HYST_1P5, TSA_HYST_3, TSA_HYST_6} tsa_hyst_t;
endpackage : tsa_pkg

/* File: hw/tsa_regs.svh */
// register offsets, field positions, reset values and hysteresis steps of the alarm block
`ifndef TSA_REGS_SVH
`define TSA_REGS_SVH

`define TSA_ADDR_CFG 8'h01
`define TSA_ADDR_HIGH 8'h02
`define TSA_ADDR_LOW 8'h03
`define TSA_ADDR_CRIT 8'h04
`define TSA_ADDR_TEMP 8'h05

`define TSA_CFG_RESET 16'h0001
`define TSA_LIMIT_RESET 11'h000
`define TSA_TEMP_RESET 13'h0000

`define TSA_CFG_HYST_HI 10
`define TSA_CFG_HYST_LO 9
`define TSA_CFG_POWER_DOWN_CTL 8
`define TSA_CFG_CRIT_LOCK 7
`define TSA_CFG_WIN_LOCK 6
`define TSA_CFG_RELEASE 5
`define TSA_CFG_STS 4
`define TSA_CFG_ENABLE 3
`define TSA_CFG_CONLY 2
`define TSA_CFG_POL 1
`define TSA_CFG_MODE 0

`define TSA_TEMP_ST_CRIT 15
`define TSA_TEMP_ST_HIGH 14
`define TSA_TEMP_ST_LOW 13
`define TSA_TEMP_MSB 12
`define TSA_CMP_LSB 2

// hysteresis in quarter-degree compare steps: 1.5, 3 and 6 degrees
`define TSA_HYST_Q_1P5 12'h006
`define TSA_HYST_Q_3 12'h00C
`define TSA_HYST_Q_6 12'h018

// visible temperature bits per resolution code
`define TSA_RES_MASK_9 13'h1FF8
`define TSA_RES_MASK_10 13'h1FFC
`define TSA_RES_MASK_11 13'h1FFE
`define TSA_RES_MASK_12 13'h1FFF

`endif

/* File: tb/tsa_alarm_bench.sv */
// self-checking bench of the thermal alarm block
`timescale 1ns/1ps
`include "tsa_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module tsa_alarm_bench;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst = 1'b1;
    logic [12:0] temp_sample = 13'h0000;
    logic sample_valid = 1'b0;
    logic [1:0] resolution_code = 2'h1;
    logic converter_enable, lnk_req, lnk_wr, lnk_busy, lnk_done, alarm_pin_o, alarm_pin_oe;
    logic [7:0] lnk_addr;
    logic [15:0] lnk_wdata, lnk_rdata;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic [12:0] last_t = 13'h0000;
    logic shd = 1'b0;
    int err_count = 0;
    int checks = 0;

    always #2.5 clk_sys = ~clk_sys;
    initial begin
        #17;
        forever #40 clk_link = ~clk_link;
    end

    tsa_alarm dut_u (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
        .temp_sample(temp_sample), .sample_valid(sample_valid),
        .resolution_code(resolution_code), .converter_enable(converter_enable),
        .lnk_req(lnk_req), .lnk_wr(lnk_wr), .lnk_addr(lnk_addr), .lnk_wdata(lnk_wdata),
        .lnk_busy(lnk_busy), .lnk_done(lnk_done), .lnk_rdata(lnk_rdata),
        .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe));
    tsa_host_model host_u (.clk_link(clk_link), .lnk_req(lnk_req), .lnk_wr(lnk_wr),
        .lnk_addr(lnk_addr), .lnk_wdata(lnk_wdata), .lnk_busy(lnk_busy),
        .lnk_done(lnk_done));

    // every finished access retires the oldest note
    always @(negedge clk_link) begin
        if (lnk_done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[16]) `CHK(lnk_rdata, e[15:0])
        end
    end

    function automatic logic [15:0] tq(input int q);
        return {3'b000, 13'(q * 4)};
    endfunction : tq

    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        exp_q.push_back({1'b1, x});
        host_u.xfer(1'b0, a, 16'h0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        exp_q.push_back({1'b0, 16'h0000});
        host_u.xfer(1'b1, a, d);
    endtask : wr

    task automatic pin(input logic x);
        repeat (4) @(negedge clk_sys);
        `CHK(alarm_pin_oe, x)
        `CHK(alarm_pin_o, 1'b0)
    endtask : pin

    // random sub-compare bits and resolution must not move any decision
    task automatic smp(input int q, input logic x);
        logic [1:0] r;
        logic [12:0] c;
        r = 2'($urandom);
        c = 13'(q * 4) | 13'($urandom & 3);
        @(negedge clk_sys);
        temp_sample = c;
        resolution_code = r;
        sample_valid = 1'b1;
        @(negedge clk_sys);
        sample_valid = 1'b0;
        if (!shd) begin
            last_t = c & (r == 2'h0 ? `TSA_RES_MASK_9 : r == 2'h1 ? `TSA_RES_MASK_10 :
                r == 2'h2 ? `TSA_RES_MASK_11 : `TSA_RES_MASK_12);
        end
        pin(x);
    endtask : smp

    task automatic rt(input logic [2:0] st);
        rd(`TSA_ADDR_TEMP, {st, last_t});
    endtask : rt

    // link side resets through a synchroniser, so hold past a few link edges
    task automatic do_reset;
        rst = 1'b1;
        repeat (20) @(negedge clk_sys);
        repeat (4) @(posedge clk_link);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (5) @(posedge clk_link);
    endtask : do_reset

    task automatic finish_test;
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(32'ha596fbde));
        do_reset();
        rd(`TSA_ADDR_CFG, `TSA_CFG_RESET);
        rd(`TSA_ADDR_HIGH, 16'h0000);
        rd(`TSA_ADDR_LOW, 16'h0000);
        rd(`TSA_ADDR_CRIT, 16'h0000);
        rt(3'b000);
        rd(8'h06, 16'h0000);
        wr(`TSA_ADDR_HIGH, tq(80));
        wr(`TSA_ADDR_LOW, tq(-10));
        wr(`TSA_ADDR_CRIT, tq(120));
        rd(`TSA_ADDR_HIGH, 16'h0140);
        rd(`TSA_ADDR_LOW, 16'h1FD8);
        rd(`TSA_ADDR_CRIT, 16'h01E0);
        wr(`TSA_ADDR_CFG, 16'h0008);
        smp(100, 1'b1);
        rd(`TSA_ADDR_CFG, 16'h0018);
        rt(3'b010);
        wr(`TSA_ADDR_CFG, 16'h0208);
        smp(76, 1'b1);
        smp(74, 1'b0);
        rt(3'b000);
        smp(-16, 1'b0);
        smp(-18, 1'b1);
        rt(3'b001);
        smp(-10, 1'b0);
        wr(`TSA_ADDR_CFG, 16'h020C);
        smp(100, 1'b0);
        smp(124, 1'b1);
        smp(116, 1'b1);
        rt(3'b110);
        smp(114, 1'b0);
        smp(60, 1'b0);
        wr(`TSA_ADDR_CFG, 16'h0009);
        wr(`TSA_ADDR_CFG, 16'h0029);
        pin(1'b0);
        smp(100, 1'b1);
        wr(`TSA_ADDR_CFG, 16'h0029);
        pin(1'b0);
        rd(`TSA_ADDR_CFG, 16'h0009);
        smp(104, 1'b0);
        smp(60, 1'b1);
        wr(`TSA_ADDR_CFG, 16'h0008);
        pin(1'b0);
        smp(100, 1'b1);
        wr(`TSA_ADDR_CFG, 16'h0028);
        pin(1'b1);
        rd(`TSA_ADDR_CFG, 16'h0018);
        wr(`TSA_ADDR_CFG, 16'h000A);
        pin(1'b0);
        smp(60, 1'b1);
        wr(`TSA_ADDR_CFG, 16'h0000);
        smp(100, 1'b0);
        rd(`TSA_ADDR_CFG, 16'h0000);
        wr(`TSA_ADDR_CFG, 16'h0108);
        pin(1'b1);
        `CHK(converter_enable, 1'b0)
        shd = 1'b1;
        smp(60, 1'b1);
        rt(3'b010);
        rd(`TSA_ADDR_CFG, 16'h0118);
        wr(`TSA_ADDR_CFG, 16'h0148);
        rd(`TSA_ADDR_CFG, 16'h0158);
        wr(`TSA_ADDR_CFG, 16'h0048);
        shd = 1'b0;
        `CHK(converter_enable, 1'b1)
        smp(60, 1'b0);
        rd(`TSA_ADDR_CFG, 16'h0048);
        wr(`TSA_ADDR_HIGH, tq(160));
        rd(`TSA_ADDR_HIGH, tq(80));
        wr(`TSA_ADDR_LOW, tq(0));
        rd(`TSA_ADDR_LOW, tq(-10));
        wr(`TSA_ADDR_CFG, 16'h0744);
        rd(`TSA_ADDR_CFG, 16'h0048);
        wr(`TSA_ADDR_CRIT, tq(124));
        rd(`TSA_ADDR_CRIT, tq(124));
        wr(`TSA_ADDR_CFG, 16'h00C8);
        wr(`TSA_ADDR_CRIT, tq(200));
        rd(`TSA_ADDR_CRIT, tq(124));
        wr(`TSA_ADDR_CFG, 16'h0008);
        rd(`TSA_ADDR_CFG, 16'h00C8);
        do_reset();
        rd(`TSA_ADDR_CFG, `TSA_CFG_RESET);
        rd(`TSA_ADDR_CRIT, 16'h0000);
        repeat (10) @(negedge clk_link);
        `CHK(exp_q.size() == 0, 1'b1)
        finish_test();
    end
endmodule : tsa_alarm_bench

/* File: tb/tsa_host_model.sv */
// link-side host model issuing one register access at a time
`timescale 1ns/1ps
module tsa_host_model (
    // link clock
    input wire logic clk_link,
    // link port
    output logic lnk_req,
    output logic lnk_wr,
    output logic [7:0] lnk_addr,
    output logic [15:0] lnk_wdata,
    input wire logic lnk_busy,
    input wire logic lnk_done
);
    initial begin
        lnk_req = 1'b0;
        lnk_wr = 1'b0;
        lnk_addr = 8'h00;
        lnk_wdata = 16'h0000;
    end

    // entered only after the previous done, so busy is low at the take edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk_link);
        lnk_req = 1'b1;
        lnk_wr = wr;
        lnk_addr = a;
        lnk_wdata = d;
        @(posedge clk_link);
        @(negedge clk_link);
        // released lines carry the inverse, not a stale copy
        lnk_req = 1'b0;
        lnk_wr = ~wr;
        lnk_addr = ~a;
        lnk_wdata = ~d;
        while (lnk_done !== 1'b1 && n < 20) begin
            @(negedge clk_link);
            n++;
        end
    endtask : xfer
endmodule : tsa_host_model
